// File: rtl/pmg_phy_mgmt.sv
// Indirect PHY register access unit behind an AXI4-Lite port.
// Assumes one synchronous clock and internal PHYs on the management line.
module pmg_phy_mgmt
  import pmg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Merges the two low byte lanes of a write into a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  // True when the word address names a register of this block
  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == OFF_DATA) || (addr == OFF_ACCESS);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic awHeld; // Write address taken, not yet used
  logic [11:0] awAddr;
  logic wHeld; // Write data taken, not yet used
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [1:0] brespQ;
  logic [31:0] rdataQ;
  logic [1:0] rrespQ;
  logic [15:0] hostData; // Value software last wrote
  logic [15:0] phyData; // Value last returned by a PHY
  logic [4:0] phyAddr; // Target PHY number
  logic [4:0] regIdx; // PHY register index
  logic wrSel; // One for a write operation
  pmg_state_t state; // Idle or busy
  logic next_awHeld, next_wHeld, next_bvalid, next_rvalid, next_wrSel;
  logic [11:0] next_awAddr;
  logic [31:0] next_wData, next_rdata;
  logic [3:0] next_wStrb;
  logic [1:0] next_bresp, next_rresp;
  logic [15:0] next_hostData, next_phyData;
  logic [4:0] next_phyAddr, next_regIdx;
  pmg_state_t next_state;
  logic doWrite; // Address and data both present
  logic launch; // Access register written while idle
  logic [15:0] accView; // Access register low half
  logic [15:0] accNew; // Access register after byte merge
  logic tick; // Half-period enable of the management clock
  logic engBusy, engDone;
  logic [15:0] engRdData;

  // Handshake outputs straight from the holding flags
  assign awready = !awHeld;
  assign wready = !wHeld;
  assign arready = !rvalid;
  assign bresp = brespQ;
  assign rdata = rdataQ;
  assign rresp = rrespQ;

  // Busy shows the sequencer state in the access register
  assign accView = {phyAddr, regIdx, 4'h0, wrSel, state == ST_BUSY};
  assign accNew = merge16(accView, wData[15:0], wStrb[1:0]);
  assign doWrite = awHeld && wHeld && !bvalid;
  // A write during busy is dropped so a running frame is never cut short
  assign launch = doWrite && awAddr == OFF_ACCESS && state == ST_IDLE;

  // ----------------------------------------
  // Bus channels
  // ----------------------------------------
  // Address and data are held independently, so either may come first
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = bvalid;
    next_bresp = brespQ;
    next_rvalid = rvalid;
    next_rdata = rdataQ;
    next_rresp = rrespQ;
    // Write address capture
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddr = {awaddr[11:2], 2'b00};
    end
    // Write data capture
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wData = wdata;
      next_wStrb = wstrb;
    end
    // Write response once both halves are in
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // Read answer one cycle after the address
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case ({araddr[11:2], 2'b00})
        OFF_DATA: begin
          next_rdata = {16'h0000, wrSel ? hostData : phyData};
        end
        OFF_ACCESS: begin
          next_rdata = {16'h0000, accView};
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      bvalid <= 1'b0;
      brespQ <= RESP_OKAY;
      rvalid <= 1'b0;
      rdataQ <= 32'h00000000;
      rrespQ <= RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bvalid <= next_bvalid;
      brespQ <= next_bresp;
      rvalid <= next_rvalid;
      rdataQ <= next_rdata;
      rrespQ <= next_rresp;
    end
  end

  // ----------------------------------------
  // Registers and access sequencer
  // ----------------------------------------
  // The host copy and the PHY copy are kept apart so a read never
  // destroys what software wrote, and the readback picks between them
  always_comb begin
    next_hostData = hostData;
    next_phyData = phyData;
    next_phyAddr = phyAddr;
    next_regIdx = regIdx;
    next_wrSel = wrSel;
    next_state = state;
    // Data field writes; software keeps it stable while busy
    if (doWrite && awAddr == OFF_DATA) begin
      next_hostData = merge16(hostData, wData[15:0], wStrb[1:0]);
    end
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_phyAddr = accNew[PHY_MSB:PHY_LSB];
          next_regIdx = accNew[REG_MSB:REG_LSB];
          next_wrSel = accNew[WSEL_BIT];
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (engDone) begin
          next_state = ST_IDLE;
          if (!wrSel) begin
            next_phyData = engRdData;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hostData <= DATA_RST;
      phyData <= DATA_RST;
      phyAddr <= FIELD5_RST;
      regIdx <= FIELD5_RST;
      wrSel <= 1'b0;
      state <= ST_IDLE;
    end else begin
      hostData <= next_hostData;
      phyData <= next_phyData;
      phyAddr <= next_phyAddr;
      regIdx <= next_regIdx;
      wrSel <= next_wrSel;
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Management line
  // ----------------------------------------
  // Only the real PHYs hang on this line; no virtual PHY decode here
  pmg_mdc_div u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(engBusy),
    .tick(tick)
  );

  // Host data is taken at launch, which is why it must be loaded first
  pmg_mdio_engine u_eng (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(launch),
    .opWrite(accNew[WSEL_BIT]),
    .phyAddr(accNew[PHY_MSB:PHY_LSB]),
    .regIdx(accNew[REG_MSB:REG_LSB]),
    .wrData(hostData),
    .tick(tick),
    .busy(engBusy),
    .done(engDone),
    .rdData(engRdData),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  busy_on_launch_a: assert property (launch |=> accView[BUSY_BIT] ##1 engBusy)
    else $error("busy not set by access write");
  busy_holds_a: assert property (state == ST_BUSY && !engDone |=> state == ST_BUSY)
    else $error("busy dropped before completion");
  busy_clears_a: assert property (state == ST_BUSY && engDone |=> !accView[BUSY_BIT])
    else $error("busy not cleared at completion");
  read_loads_a: assert property (state == ST_BUSY && engDone && !wrSel
    |=> phyData == $past(engRdData))
    else $error("read result not loaded");
  write_keeps_a: assert property (engDone && wrSel |=> $stable(phyData))
    else $error("write changed returned data");
  phy_view_a: assert property (arvalid && arready && araddr == OFF_DATA && !wrSel
    |=> rvalid && rdata == {16'h0000, $past(phyData)})
    else $error("data readback not from PHY");
  host_view_a: assert property (arvalid && arready && araddr == OFF_DATA && wrSel
    |=> rdata == {16'h0000, $past(hostData)})
    else $error("data readback not host value");
  data_reset_a: assert property (disable iff (1'b0) !reset_n |=> hostData == DATA_RST
    && phyData == DATA_RST)
    else $error("data field not zero after reset");
  field_capture_a: assert property (launch |=> phyAddr == $past(accNew[PHY_MSB:PHY_LSB])
    && regIdx == $past(accNew[REG_MSB:REG_LSB]))
    else $error("access fields not captured");
  read_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  write_op_c: cover property (launch && accNew[WSEL_BIT] ##[1:8] engBusy);
  read_done_c: cover property (state == ST_BUSY && engDone && !wrSel);
  data_read_c: cover property (arvalid && arready && araddr == OFF_DATA);
  bad_addr_c: cover property (bvalid && bresp == RESP_SLVERR);

endmodule

// File: rtl/pmg_pkg.sv
// Constants and types of the PHY management access block.
// Assumes a 250 MHz system clock and an AXI4-Lite register port.
package pmg_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_DATA = 12'h0A4; // Data register
  localparam logic [11:0] OFF_ACCESS = 12'h0A8; // Access register
  localparam logic [15:0] DATA_RST = 16'h0000; // Data field reset
  localparam logic [4:0] FIELD5_RST = 5'h00; // Address and index reset

  // ----------------------------------------
  // Access register fields
  // ----------------------------------------
  localparam int PHY_MSB = 15;
  localparam int PHY_LSB = 11;
  localparam int REG_MSB = 10;
  localparam int REG_LSB = 6;
  localparam int WSEL_BIT = 1;
  localparam int BUSY_BIT = 0;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Management clock timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int MDC_HALF_NS = 200; // Least half period of the clock
  localparam logic [6:0] MDC_HALF_CYC = 7'((MDC_HALF_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------
  // Management frame layout
  // ----------------------------------------
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] FRM_START = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_READ = 2'h3; // Not driven
  localparam logic [5:0] TA_IDX = 6'h2E; // First turnaround bit
  localparam logic [5:0] DATA_IDX = 6'h30; // First data bit
  localparam logic [5:0] LAST_IDX = 6'h3F; // Last bit of the frame

  // Access sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } pmg_state_t;

endpackage

// File: rtl/pmg_mdc_div.sv
// Divider giving the half-period enable of the management clock.
// Assumes run stays high for a whole frame.
module pmg_mdc_div
  import pmg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  output logic tick
);

  logic [6:0] cnt; // Cycles within one half period
  logic [6:0] next_cnt;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Restarts at zero so every frame starts with a full half period
  always_comb begin
    tick = run && (cnt == MDC_HALF_CYC - 7'h01);
    if (!run || tick) begin
      next_cnt = 7'h00;
    end else begin
      next_cnt = cnt + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt <= 7'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// File: rtl/pmg_mdio_engine.sv
// Shifts one clause 22 management frame out and in.
// Assumes tick comes from pmg_mdc_div and mdioIn is synchronous.
module pmg_mdio_engine
  import pmg_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic opWrite,
  input wire logic [4:0] phyAddr,
  input wire logic [4:0] regIdx,
  input wire logic [15:0] wrData,
  input wire logic tick,
  output logic busy,
  output logic done,
  output logic [15:0] rdData,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);

  logic [63:0] frame; // Bits still to send, MSB first
  logic [5:0] bitCnt; // Current bit slot
  logic isWrite; // Direction of the frame
  logic [63:0] next_frame;
  logic [5:0] next_bitCnt;
  logic next_isWrite, next_busy, next_done, next_mdc, next_oe;
  logic [15:0] next_rdData;

  assign mdioOut = frame[63];

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // Data moves on the falling edge and is sampled on the rising one
  always_comb begin
    next_frame = frame;
    next_bitCnt = bitCnt;
    next_isWrite = isWrite;
    next_busy = busy;
    next_done = 1'b0;
    next_mdc = mdc;
    next_rdData = rdData;
    if (start && !busy) begin
      next_frame = {PREAMBLE, FRM_START, opWrite ? OP_WRITE : OP_READ, phyAddr, regIdx,
                    opWrite ? TA_WRITE : TA_READ, wrData};
      next_bitCnt = 6'h00;
      next_isWrite = opWrite;
      next_busy = 1'b1;
      next_mdc = 1'b0;
    end else if (busy && tick) begin
      if (!mdc) begin
        next_mdc = 1'b1;
        // Capture the returned data bits
        if (!isWrite && bitCnt >= DATA_IDX) begin
          next_rdData = {rdData[14:0], mdioIn};
        end
      end else begin
        next_mdc = 1'b0;
        if (bitCnt == LAST_IDX) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_bitCnt = bitCnt + 6'h01;
          next_frame = {frame[62:0], 1'b0};
        end
      end
    end
    // The PHY owns the line from turnaround on in a read
    next_oe = next_busy && (next_isWrite || next_bitCnt < TA_IDX);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      frame <= 64'h0000000000000000;
      bitCnt <= 6'h00;
      isWrite <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      mdc <= 1'b0;
      mdioOe <= 1'b0;
      rdData <= 16'h0000;
    end else begin
      frame <= next_frame;
      bitCnt <= next_bitCnt;
      isWrite <= next_isWrite;
      busy <= next_busy;
      done <= next_done;
      mdc <= next_mdc;
      mdioOe <= next_oe;
      rdData <= next_rdData;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  read_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
    busy && !isWrite && bitCnt >= TA_IDX |-> !mdioOe)
    else $error("line driven during read turnaround");
  start_drive_a: assert property (@(posedge mclk) disable iff (!reset_n)
    start && !busy |=> mdioOe && mdioOut && !mdc)
    else $error("frame did not start with driven preamble");

endmodule

// File: testbench/pmg_phy_model.sv
// Behavioural internal PHY on the management line, answering read frames.
// Assumes mdc stands low between frames and the line has a pull-up.
module pmg_phy_model (
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic slow,
  input wire logic [15:0] rdValue,
  output logic mdioIn,
  output logic [63:0] frame,
  output int frameCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic phyOe = 1'b0; // High while this PHY drives the line
  logic phyOut = 1'b0; // Bit offered by this PHY
  logic isRead = 1'b0; // Frame under way is a read
  logic [63:0] shiftReg = '0; // Every sampled bit, first bit ends at the top
  int cnt = 0; // Index of the next bit of the frame

  // --------------------------------
  // Line level
  // --------------------------------
  // Released line floats up, so a stale driven value never shows
  assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);

  // Sample on the rising clock edge and decode the frame
  always @(posedge mdc) begin
    shiftReg = {shiftReg[62:0], mdioIn};
    if (cnt == 35) begin
      isRead = (shiftReg[1:0] == 2'b10);
    end
    cnt = cnt + 1;
    if (cnt == 64) begin
      frame = shiftReg;
      frameCount = frameCount + 1;
      cnt = 0;
    end
  end

  // Drive the second turnaround bit low then read data MSB first after each falling edge
  always @(negedge mdc) begin
    // Slow answer still settles well inside the half period
    if (slow) begin
      #60;
    end
    phyOe = isRead && (cnt >= 47);
    phyOut = (cnt == 47) ? 1'b0 : rdValue[(63 - cnt) & 15];
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench of the PHY management access block.
// Assumes the PHY model above and the package constants of the design.
module tb_top
  import pmg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mdc, mdioIn, mdioOut, mdioOe, slow;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, lastRd, rnd, wd, acc;
  logic [1:0] bresp, rresp;
  logic [15:0] rdValue;
  logic [63:0] frame;
  logic [3:0] wstrb; // Byte lanes of the write data
  int frameCount, cyc, miscompares, n_tests;
  logic [63:0] rq[$], mq[$], bq[$], fq[$]; // Expected results and read masks in order

  pmg_phy_mgmt u_pmg_phy_mgmt (.mclk(mclk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));

  pmg_phy_model u_pmg_phy_model (.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .slow(slow),
    .rdValue(rdValue), .mdioIn(mdioIn), .frame(frame), .frameCount(frameCount));

  // --------------------------------
  // Clock, cycle count and checking
  // --------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Watcher takes the oldest note whenever a result shows up
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      compare({30'h0, rresp, rdata} & mq.pop_front(), rq.pop_front());
    end
    if (bvalid && bready) begin
      compare(64'(bresp), bq.pop_front());
    end
  end

  always @(frameCount) compare(frame, fq.pop_front());

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // --------------------------------
  // Bus master tasks
  // --------------------------------
  // Address and data offered together, each dropped on its own take
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit awDone;
    bit wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    bq.push_back(64'(er));
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge mclk);
      if (!awDone && awready) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
  endtask

  // Mask hides bits whose value the bench cannot foresee
  task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
                          input logic [31:0] m);
    rq.push_back({30'h0, er, e & m});
    mq.push_back({32'hFFFFFFFF, m});
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    lastRd = rdata;
  endtask

  // Launch, try a refused relaunch, poll until idle, check duration
  task automatic run_op(input logic [31:0] a, input logic [63:0] expFrame);
    logic [31:0] expAcc;
    int t0;
    expAcc = {16'h0, a[15:6], 4'h0, a[1], 1'b1};
    t0 = cyc;
    fq.push_back(expFrame);
    axi_write(OFF_ACCESS, a, RESP_OKAY);
    axi_read(OFF_ACCESS, expAcc, RESP_OKAY, 32'hFFFFFFFF);
    axi_write(OFF_ACCESS, ~a, RESP_OKAY);
    axi_read(OFF_ACCESS, expAcc, RESP_OKAY, 32'hFFFFFFFF);
    do begin
      axi_read(OFF_ACCESS, expAcc, RESP_OKAY, 32'hFFFFFFFE);
    end while (lastRd[0] !== 1'b0);
    compare(64'((cyc - t0) >= 128 * MDC_HALF_CYC && (cyc - t0) <= 128 * MDC_HALF_CYC + 100), 64'h1);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Three frames of about 6400 cycles each fit well inside this span
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares = miscompares + 1;
    $display("Watchdog expired at %0t", $time);
    stop_test();
  end

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    // Both answer readies stay high; no request is offered during reset
    {reset_n, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h0A;
    {awaddr, araddr, wdata, rdValue} = '0;
    wstrb = 4'hF;
    {cyc, miscompares, n_tests} = '0;
    rnd = 32'h00015E78;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    axi_read(OFF_DATA, 32'h0, RESP_OKAY, 32'hFFFFFFFF);
    axi_read(OFF_ACCESS, 32'h0, RESP_OKAY, 32'hFFFFFFFF);
    $display("Test reset values done");
    axi_write(12'h0AC, 32'h00001234, RESP_SLVERR);
    axi_read(12'h0AC, 32'h0, RESP_SLVERR, 32'hFFFFFFFF);
    $display("Test unmapped address done");
    rnd = lfsr_next(rnd);
    wd = rnd;
    axi_write(OFF_DATA, wd, RESP_OKAY);
    axi_read(OFF_DATA, 32'h0, RESP_OKAY, 32'hFFFFFFFF);
    repeat (5) rnd = lfsr_next(rnd);
    acc = {16'h0, rnd[15:6], 6'h02};
    run_op(acc, {32'hFFFFFFFF, FRM_START, OP_WRITE, acc[15:6], TA_WRITE, wd[15:0]});
    axi_read(OFF_DATA, {16'h0, wd[15:0]}, RESP_OKAY, 32'hFFFFFFFF);
    // Only the upper byte lane is written, the lower byte must survive
    wstrb <= 4'h2;
    axi_write(OFF_DATA, 32'h0000C35A, RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(OFF_DATA, {16'h0, 8'hC3, wd[7:0]}, RESP_OKAY, 32'hFFFFFFFF);
    $display("Test management write done");
    // Second read answers late to stress the sampling point
    for (int k = 0; k < 2; k++) begin
      repeat (7) rnd = lfsr_next(rnd);
      slow <= k[0];
      rdValue <= rnd[31:16];
      acc = {16'h0, rnd[15:6], 6'h00};
      run_op(acc, {32'hFFFFFFFF, FRM_START, OP_READ, acc[15:6], 2'b10, rnd[31:16]});
      axi_read(OFF_DATA, {16'h0, rnd[31:16]}, RESP_OKAY, 32'hFFFFFFFF);
      $display("Test management read %0d done", k);
    end
    repeat (3) @(posedge mclk);
    stop_test();
  end
endmodule
